/* src/cpu_address_register_file_consts.vh */
// constants shared by the core register file and its bus slave
`ifndef CPU_ADDRESS_REGISTER_FILE_CONSTS_VH
`define CPU_ADDRESS_REGISTER_FILE_CONSTS_VH

// architectural totals and widths
`define REG_TOTAL_COUNT 28
`define REG_WIDTH 32
`define MOD_WIDTH 16
`define GPR_COUNT 8

// core-side register selectors
`define SEL_PC 4'h8
`define SEL_SP 4'h9
`define SEL_FP 4'ha
`define SEL_SB 4'hb
`define SEL_DISPATCH_TABLE_BASE 4'hc
`define SEL_MOD 4'hd
`define SEL_USP_DIRECT 4'he
`define SEL_ISP_DIRECT 4'hf

// operand sizes
`define SIZE_BYTE 2'h0
`define SIZE_WORD 2'h1
`define SIZE_DWORD 2'h3

// bus word indices
`define BUS_IDX_PC 5'h08
`define BUS_IDX_ISP 5'h09
`define BUS_IDX_USP 5'h0a
`define BUS_IDX_FP 5'h0b
`define BUS_IDX_SB 5'h0c
`define BUS_IDX_DISPATCH_TABLE_BASE 5'h0d
`define BUS_IDX_MOD 5'h0e
`define BUS_IDX_CTRL 5'h0f

// control register field
`define CTRL_STACK_SEL_BIT 0

// reset values
`define RESET_VALUE 32'h00000000
`define MOD_RESET_VALUE 16'h0000
`define STACK_SEL_RESET 1'b0

`endif

/* src/cpu_address_register_file.v */
// architectural register file: general, address and stack registers with bus access
`timescale 1ns/1ps
`include "cpu_address_register_file_consts.vh"

module cpu_address_register_file #(
   parameter DATA_W = 32,
   parameter BUS_ADDR_W = 5
) (
   input wire i_clk_sys,
   input wire i_reset,
   // core read ports
   input wire [3:0] i_rd_sel_a,
   input wire [1:0] i_rd_size_a,
   input wire [3:0] i_rd_sel_b,
   input wire [1:0] i_rd_size_b,
   output reg [DATA_W-1:0] o_rd_data_a,
   output reg [DATA_W-1:0] o_rd_data_b,
   // core write port
   input wire i_wr_en,
   input wire [3:0] i_wr_sel,
   input wire [1:0] i_wr_size,
   input wire [DATA_W-1:0] i_wr_data,
   // program counter
   input wire i_pc_load,
   input wire [DATA_W-1:0] i_pc_next,
   output reg [DATA_W-1:0] o_program_counter,
   // stack operations
   input wire i_push,
   input wire i_pop,
   input wire [2:0] i_stack_len,
   output reg [DATA_W-1:0] o_stack_addr,
   output reg [DATA_W-1:0] o_stack_pointer,
   // procedure entry and exit
   input wire i_enter,
   input wire i_exit,
   input wire [DATA_W-1:0] i_exit_fp_value,
   output reg [DATA_W-1:0] o_frame_pointer,
   // stack select and exceptions
   input wire i_stack_sel_wr,
   input wire i_stack_sel_value,
   input wire i_trap_entry,
   output reg o_stack_select,
   output reg [DATA_W-1:0] o_static_base,
   output reg [DATA_W-1:0] o_dispatch_table_base,
   output reg [DATA_W-1:0] o_module_descriptor_pointer,
   // avalon-mm slave
   input wire [BUS_ADDR_W-1:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   input wire [3:0] i_avs_byteenable,
   output reg [31:0] o_avs_readdata,
   output reg o_avs_waitrequest
);

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   // 15 of the 28 registers live here; status, config, mmu and debug sit elsewhere
   reg [DATA_W-1:0] general_reg_q [0:`GPR_COUNT-1];
   reg [DATA_W-1:0] program_counter_q;
   reg [DATA_W-1:0] isp_q;
   reg [DATA_W-1:0] usp_q;
   reg [DATA_W-1:0] frame_pointer_q;
   reg [DATA_W-1:0] static_base_q;
   reg [DATA_W-1:0] dispatch_table_base_q;
   reg [`MOD_WIDTH-1:0] module_descriptor_pointer_q;
   reg stack_sel_q;
   integer k;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------

   // merge new data into old by operand size, upper part untouched
   function [DATA_W-1:0] size_merge;
      input [DATA_W-1:0] old_v;
      input [DATA_W-1:0] new_v;
      input [1:0] size;
      begin
         case (size)
            `SIZE_BYTE: size_merge = {old_v[DATA_W-1:8], new_v[7:0]};
            `SIZE_WORD: size_merge = {old_v[DATA_W-1:16], new_v[15:0]};
            default: size_merge = new_v;
         endcase
      end
   endfunction

   // low part of a value for narrow reads
   function [DATA_W-1:0] size_mask;
      input [DATA_W-1:0] v;
      input [1:0] size;
      begin
         case (size)
            `SIZE_BYTE: size_mask = {{(DATA_W-8){1'b0}}, v[7:0]};
            `SIZE_WORD: size_mask = {{(DATA_W-16){1'b0}}, v[15:0]};
            default: size_mask = v;
         endcase
      end
   endfunction

   // apply avalon byte enables
   function [31:0] be_merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0] be;
      integer b;
      begin
         be_merge = old_v;
         for (b = 0; b < 4; b = b + 1) begin
            if (be[b]) begin
               be_merge[b*8 +: 8] = new_v[b*8 +: 8];
            end
         end
      end
   endfunction

   // current stack pointer chosen by stack select
   function [DATA_W-1:0] cur_sp;
      input sel;
      input [DATA_W-1:0] isp;
      input [DATA_W-1:0] direct_user_stack_access;
      begin
         cur_sp = sel ? direct_user_stack_access : isp;
      end
   endfunction

   // core-side read decode
   function [DATA_W-1:0] core_read;
      input [3:0] sel;
      begin
         case (sel)
            `SEL_PC: core_read = program_counter_q;
            `SEL_SP: core_read = cur_sp(stack_sel_q, isp_q, usp_q);
            `SEL_FP: core_read = frame_pointer_q;
            `SEL_SB: core_read = static_base_q;
            `SEL_DISPATCH_TABLE_BASE: core_read = dispatch_table_base_q;
            `SEL_MOD: core_read = {{(DATA_W-`MOD_WIDTH){1'b0}}, module_descriptor_pointer_q};
            `SEL_USP_DIRECT: core_read = usp_q;
            `SEL_ISP_DIRECT: core_read = isp_q;
            default: core_read = general_reg_q[sel[2:0]];
         endcase
      end
   endfunction

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   reg [31:0] bus_rd_value;
   reg [31:0] bus_old;
   reg [31:0] bus_new;
   wire bus_req = i_avs_read | i_avs_write;
   wire bus_take_wr = i_avs_write & ~o_avs_waitrequest; // edge where the master sees wait low
   wire [DATA_W-1:0] sel_sp = cur_sp(stack_sel_q, isp_q, usp_q);
   wire [DATA_W-1:0] len_ext = {{(DATA_W-3){1'b0}}, i_stack_len};

   // readback for any word index; unmapped ones read zero
   always @* begin
      case (i_avs_address)
         `BUS_IDX_PC: bus_rd_value = program_counter_q;
         `BUS_IDX_ISP: bus_rd_value = isp_q;
         `BUS_IDX_USP: bus_rd_value = usp_q;
         `BUS_IDX_FP: bus_rd_value = frame_pointer_q;
         `BUS_IDX_SB: bus_rd_value = static_base_q;
         `BUS_IDX_DISPATCH_TABLE_BASE: bus_rd_value = dispatch_table_base_q;
         `BUS_IDX_MOD: bus_rd_value = {16'h0000, module_descriptor_pointer_q};
         `BUS_IDX_CTRL: bus_rd_value = {31'h00000000, stack_sel_q};
         default: begin
            if (i_avs_address < `GPR_COUNT) begin
               bus_rd_value = general_reg_q[i_avs_address[2:0]];
            end else begin
               bus_rd_value = 32'h00000000;
            end
         end
      endcase
   end

   // byte-enable merge done once, reused by every target
   // bus writes ignore operand size; byte enables alone shape the word
   always @* begin
      bus_old = bus_rd_value;
      bus_new = be_merge(bus_old, i_avs_writedata, i_avs_byteenable);
   end

   // ------------------------------------------------------------
   // bus handshake: wait one cycle, then answer for one cycle
   // ------------------------------------------------------------
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata <= 32'h00000000;
      end else if (!o_avs_waitrequest) begin
         o_avs_waitrequest <= 1'b1; // request consumed at this edge
      end else if (bus_req) begin
         // readdata is captured here for reads and writes alike and held until the next answer
         o_avs_waitrequest <= 1'b0;
         o_avs_readdata <= bus_rd_value;
      end
   end

   // ------------------------------------------------------------
   // register updates; later statements win, so core beats bus
   // ------------------------------------------------------------
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         for (k = 0; k < `GPR_COUNT; k = k + 1) begin
            general_reg_q[k] <= `RESET_VALUE;
         end
         program_counter_q <= `RESET_VALUE;
         isp_q <= `RESET_VALUE;
         usp_q <= `RESET_VALUE;
         frame_pointer_q <= `RESET_VALUE;
         static_base_q <= `RESET_VALUE;
         dispatch_table_base_q <= `RESET_VALUE;
         // the module pointer is narrower than the rest, so its reset is sized to it
         module_descriptor_pointer_q <= `MOD_RESET_VALUE;
         stack_sel_q <= `STACK_SEL_RESET;
      end else begin
         // software access, full words with byte enables
         if (bus_take_wr) begin
            case (i_avs_address)
               `BUS_IDX_PC: program_counter_q <= bus_new;
               `BUS_IDX_ISP: isp_q <= bus_new;
               `BUS_IDX_USP: usp_q <= bus_new;
               `BUS_IDX_FP: frame_pointer_q <= bus_new;
               `BUS_IDX_SB: static_base_q <= bus_new;
               `BUS_IDX_DISPATCH_TABLE_BASE: dispatch_table_base_q <= bus_new;
               `BUS_IDX_MOD: module_descriptor_pointer_q <= bus_new[15:0];
               `BUS_IDX_CTRL: stack_sel_q <= bus_new[`CTRL_STACK_SEL_BIT];
               default: begin
                  if (i_avs_address < `GPR_COUNT) begin
                     general_reg_q[i_avs_address[2:0]] <= bus_new;
                  end
               end
            endcase
         end
         // core operand write
         if (i_wr_en) begin
            case (i_wr_sel)
               `SEL_PC: program_counter_q <= i_wr_data;
               `SEL_SP: begin
                  if (stack_sel_q) begin
                     usp_q <= i_wr_data;
                  end else begin
                     isp_q <= i_wr_data;
                  end
               end
               `SEL_FP: frame_pointer_q <= i_wr_data;
               `SEL_SB: static_base_q <= i_wr_data;
               `SEL_DISPATCH_TABLE_BASE: dispatch_table_base_q <= i_wr_data;
               `SEL_MOD: module_descriptor_pointer_q <= i_wr_data[15:0];
               `SEL_USP_DIRECT: usp_q <= i_wr_data;
               `SEL_ISP_DIRECT: isp_q <= i_wr_data;
               default: begin
                  general_reg_q[i_wr_sel[2:0]] <=
                     size_merge(general_reg_q[i_wr_sel[2:0]], i_wr_data, i_wr_size);
               end
            endcase
         end
         // program counter advances to the next instruction start
         if (i_pc_load) begin
            program_counter_q <= i_pc_next;
         end
         // stack and frame operations on the selected pointer
         // the core issues one of these at a time; the priority only keeps the logic defined
         if (i_enter) begin
            // old frame pointer is pushed; frame pointer then marks its slot
            frame_pointer_q <= sel_sp - 32'h00000004;
            if (stack_sel_q) begin
               usp_q <= usp_q - 32'h00000004;
            end else begin
               isp_q <= isp_q - 32'h00000004;
            end
         end else if (i_exit) begin
            // stack unwinds past the saved slot, frame pointer restored
            frame_pointer_q <= i_exit_fp_value;
            if (stack_sel_q) begin
               usp_q <= frame_pointer_q + 32'h00000004;
            end else begin
               isp_q <= frame_pointer_q + 32'h00000004;
            end
         end else if (i_push) begin
            if (stack_sel_q) begin
               usp_q <= usp_q - len_ext;
            end else begin
               isp_q <= isp_q - len_ext;
            end
         end else if (i_pop) begin
            if (stack_sel_q) begin
               usp_q <= usp_q + len_ext;
            end else begin
               isp_q <= isp_q + len_ext;
            end
         end
         // exception entry beats a concurrent select write
         if (i_trap_entry) begin
            stack_sel_q <= 1'b0;
         end else if (i_stack_sel_wr) begin
            stack_sel_q <= i_stack_sel_value;
         end
      end
   end

   // ------------------------------------------------------------
   // registered core outputs
   // ------------------------------------------------------------
   // memory address for the stack operation, newest item lowest byte
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_stack_addr <= `RESET_VALUE;
      end else if (i_enter) begin
         o_stack_addr <= sel_sp - 32'h00000004;
      end else if (i_push) begin
         o_stack_addr <= sel_sp - len_ext;
      end else if (i_pop) begin
         o_stack_addr <= sel_sp;
      end
   end

   // read ports and architectural views, one cycle behind the select
   // both ports share one decode, so equal selects and sizes always give equal data
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_rd_data_a <= `RESET_VALUE;
         o_rd_data_b <= `RESET_VALUE;
      end else begin
         o_rd_data_a <= (i_rd_sel_a < `GPR_COUNT) ?
            size_mask(core_read(i_rd_sel_a), i_rd_size_a) : core_read(i_rd_sel_a);
         o_rd_data_b <= (i_rd_sel_b < `GPR_COUNT) ?
            size_mask(core_read(i_rd_sel_b), i_rd_size_b) : core_read(i_rd_sel_b);
      end
   end

   // mirrors of state; flat 32-bit pointers, no segment added
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_program_counter <= `RESET_VALUE;
         o_stack_pointer <= `RESET_VALUE;
         o_frame_pointer <= `RESET_VALUE;
         o_static_base <= `RESET_VALUE;
         o_dispatch_table_base <= `RESET_VALUE;
         o_module_descriptor_pointer <= `RESET_VALUE;
         o_stack_select <= `STACK_SEL_RESET;
      end else begin
         o_program_counter <= program_counter_q;
         o_stack_pointer <= sel_sp;
         o_frame_pointer <= frame_pointer_q;
         o_static_base <= static_base_q;
         o_dispatch_table_base <= dispatch_table_base_q;
         o_module_descriptor_pointer <= {16'h0000, module_descriptor_pointer_q};
         o_stack_select <= stack_sel_q;
      end
   end

endmodule

/* verification/cpu_address_register_file_sva.sv */
// port-level assertions for the core register file
`timescale 1ns/1ps
`include "cpu_address_register_file_consts.vh"
module cpu_address_register_file_sva (
   input wire i_clk_sys,
   input wire i_reset,
   input wire [3:0] i_rd_sel_a,
   input wire [3:0] i_rd_sel_b,
   input wire [31:0] o_rd_data_a,
   input wire [31:0] o_rd_data_b,
   input wire [31:0] o_program_counter,
   input wire i_push,
   input wire i_pop,
   input wire [2:0] i_stack_len,
   input wire i_enter,
   input wire i_exit,
   input wire i_stack_sel_wr,
   input wire i_stack_sel_value,
   input wire i_trap_entry,
   input wire [31:0] o_stack_addr,
   input wire [31:0] o_stack_pointer,
   input wire o_stack_select,
   input wire [31:0] o_module_descriptor_pointer,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire o_avs_waitrequest
);
   // ----
   // stack pointer, stack select, read port and bus timing
   // ----
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   // no core frame or select strobe in the start cycle; bus writes and later cycles are not excluded
   wire calm = !i_enter && !i_exit && !i_trap_entry && !i_stack_sel_wr;
   a_push_predec: assert property (i_push && calm |=>
      o_stack_addr == o_stack_pointer - {29'h0, $past(i_stack_len)}) else $error("push address wrong");
   a_pop_postinc: assert property (i_pop && !i_push && calm |=> (o_stack_addr == o_stack_pointer) ##1
      (o_stack_pointer == $past(o_stack_addr) + {29'h0, $past(i_stack_len, 2)})) else $error("pop pointer wrong");
   a_trap_clears: assert property (i_trap_entry |=> ##1 !o_stack_select) else $error("trap kept select");
   a_select_write: assert property (i_stack_sel_wr && !i_trap_entry |=> ##1
      o_stack_select == $past(i_stack_sel_value, 2)) else $error("select write lost");
   a_pc_read: assert property (i_rd_sel_a == `SEL_PC |=> o_rd_data_a == o_program_counter)
      else $error("pc read differs");
   a_mod_read: assert property (i_rd_sel_b == `SEL_MOD |=> o_rd_data_b == o_module_descriptor_pointer)
      else $error("module read differs");
   a_mod_upper: assert property (o_module_descriptor_pointer[31:16] == 16'h0000)
      else $error("module pointer upper bits set");
   a_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("bus answer late");
   a_bus_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest) else $error("wait low too long");
endmodule
bind cpu_address_register_file cpu_address_register_file_sva chk_u (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
   .i_rd_sel_a(i_rd_sel_a), .i_rd_sel_b(i_rd_sel_b), .o_rd_data_a(o_rd_data_a), .o_rd_data_b(o_rd_data_b),
   .o_program_counter(o_program_counter), .i_push(i_push), .i_pop(i_pop), .i_stack_len(i_stack_len),
   .i_enter(i_enter), .i_exit(i_exit), .i_stack_sel_wr(i_stack_sel_wr), .i_stack_sel_value(i_stack_sel_value),
   .i_trap_entry(i_trap_entry), .o_stack_addr(o_stack_addr), .o_stack_pointer(o_stack_pointer),
   .o_stack_select(o_stack_select), .o_module_descriptor_pointer(o_module_descriptor_pointer),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest));

/* verification/core_stage_model.sv */
// behavioural execute stage driving the register file core ports
`timescale 1ns/1ps
module core_stage_model (
   input wire i_clk_sys,
   output reg [7:0] o_strobe,
   output reg [3:0] o_wr_sel,
   output reg [1:0] o_wr_size,
   output reg [31:0] o_wr_data,
   output reg [2:0] o_stack_len,
   output reg [3:0] o_rd_sel_a,
   output reg [1:0] o_rd_size_a
);
   // ----
   // operation issue
   // ----
   // strobes: 0 write, 1 pc, 2 push, 3 pop, 4 enter, 5 exit, 6 select, 7 trap
   initial begin
      o_strobe = 8'h00;
      o_wr_sel = 4'h0;
      o_wr_size = 2'h3;
      o_wr_data = 32'h0;
      o_stack_len = 3'h4;
      o_rd_sel_a = 4'h0;
      o_rd_size_a = 2'h3;
   end
   // quiet cycle after each strobe so no strobe is assigned twice in a time step
   task issue(input [2:0] kind, input [31:0] v, input [3:0] sel, input [2:0] len);
      begin
         o_wr_data <= v;
         o_wr_sel <= sel;
         o_wr_size <= len[1:0];
         o_stack_len <= len;
         o_strobe <= 8'h01 << kind;
         @(posedge i_clk_sys);
         o_strobe <= 8'h00;
         o_wr_data <= ~v; // released data never keeps its last value
         @(posedge i_clk_sys);
      end
   endtask
   task point(input [3:0] sel, input [1:0] size);
      begin
         o_rd_sel_a <= sel;
         o_rd_size_a <= size;
      end
   endtask
endmodule

/* verification/cpu_address_register_file_tb.sv */
// self-checking bench for the core register file
`timescale 1ns/1ps
`include "cpu_address_register_file_consts.vh"
module cpu_address_register_file_tb;
   reg i_clk_sys = 1'b0;
   reg i_reset = 1'b1;
   reg [4:0] i_avs_address = 5'h00;
   reg i_avs_read = 1'b0;
   reg i_avs_write = 1'b0;
   reg [31:0] i_avs_writedata = 32'h0;
   reg [3:0] i_avs_byteenable = 4'hf;
   reg look = 1'b0;
   reg [1:0] look_src = 2'h0;
   reg [31:0] seed = 32'd42656;
   reg [31:0] r [0:7];
   reg [31:0] v;
   wire [31:0] o_avs_readdata;
   wire [31:0] o_rd_data_a;
   wire [31:0] o_rd_data_b;
   wire [31:0] o_frame_pointer;
   wire [31:0] o_static_base;
   wire [31:0] o_dispatch_table_base;
   wire o_avs_waitrequest;
   wire [7:0] stb;
   wire [3:0] wsel;
   wire [3:0] rsel;
   wire [1:0] wsz;
   wire [1:0] rsz;
   wire [2:0] slen;
   wire [31:0] wdat;
   logic [31:0] exp_q[$];
   integer err_total = 0;
   integer samples_checked = 0;
   integer cycles = 0;
   integer i;
   always #10 i_clk_sys = ~i_clk_sys;
   core_stage_model core_u (.i_clk_sys(i_clk_sys), .o_strobe(stb), .o_wr_sel(wsel), .o_wr_size(wsz),
      .o_wr_data(wdat), .o_stack_len(slen), .o_rd_sel_a(rsel), .o_rd_size_a(rsz));
   cpu_address_register_file dut_u (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_rd_sel_a(rsel),
      .i_rd_size_a(rsz), .i_rd_sel_b(rsel), .i_rd_size_b(rsz), .o_rd_data_a(o_rd_data_a),
      .o_rd_data_b(o_rd_data_b), .i_wr_en(stb[0]), .i_wr_sel(wsel), .i_wr_size(wsz), .i_wr_data(wdat),
      .i_pc_load(stb[1]),
      .i_pc_next(wdat), .o_program_counter(), .i_push(stb[2]), .i_pop(stb[3]), .i_stack_len(slen),
      .o_stack_addr(), .o_stack_pointer(), .i_enter(stb[4]), .i_exit(stb[5]), .i_exit_fp_value(wdat),
      .o_frame_pointer(o_frame_pointer), .i_stack_sel_wr(stb[6]), .i_stack_sel_value(wdat[0]),
      .i_trap_entry(stb[7]), .o_stack_select(), .o_static_base(o_static_base),
      .o_dispatch_table_base(o_dispatch_table_base), .o_module_descriptor_pointer(),
      .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest));
   // ----
   // helpers
   // ----
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task conclude;
      begin
         $display("checks %0d errors %0d", samples_checked, err_total);
         if (err_total == 0 && samples_checked > 0) $display("verification passed");
         else $display("verification failed");
         $finish;
      end
   endtask
   task cmp(input [31:0] got);
      reg [31:0] e;
      begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : ~got;
         samples_checked++;
         if (got !== e) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e);
         end
      end
   endtask
   // request held until waitrequest is sampled low, then one idle edge
   task bus_wr(input [4:0] a, input [31:0] d, input [3:0] be);
      begin
         i_avs_address <= a;
         i_avs_writedata <= d;
         i_avs_byteenable <= be;
         i_avs_write <= 1'b1;
         do @(posedge i_clk_sys); while (o_avs_waitrequest !== 1'b0);
         i_avs_write <= 1'b0;
         @(posedge i_clk_sys);
      end
   endtask
   task bus_rd(input [4:0] a, input [31:0] e);
      begin
         exp_q.push_back(e);
         i_avs_address <= a;
         i_avs_read <= 1'b1;
         do @(posedge i_clk_sys); while (o_avs_waitrequest !== 1'b0);
         i_avs_read <= 1'b0;
         @(posedge i_clk_sys);
      end
   endtask
   // read port data is registered, so it is looked at two edges after the select
   task core_rd(input [3:0] sel, input [1:0] size, input [31:0] e);
      begin
         core_u.point(sel, size);
         @(posedge i_clk_sys);
         exp_q.push_back(e); // port a
         exp_q.push_back(e); // port b follows the same select
         look <= 1'b1;
         @(posedge i_clk_sys);
         look <= 1'b0;
      end
   endtask
   // registered views are steady between operations, so one edge of looking is enough
   task view_rd(input [1:0] src, input [31:0] e);
      begin
         exp_q.push_back(e);
         look_src <= src;
         look <= 1'b1;
         @(posedge i_clk_sys);
         look <= 1'b0;
         look_src <= 2'h0;
      end
   endtask
   // monitor takes the oldest note whenever a result appears
   always @(posedge i_clk_sys) begin
      if (!i_reset && i_avs_read && o_avs_waitrequest === 1'b0) cmp(o_avs_readdata);
      if (look && look_src == 2'h0) begin
         cmp(o_rd_data_a);
         cmp(o_rd_data_b);
      end
      if (look && look_src == 2'h1) cmp(o_frame_pointer);
      if (look && look_src == 2'h2) cmp(o_static_base);
      if (look && look_src == 2'h3) cmp(o_dispatch_table_base);
   end
   always @(posedge i_clk_sys) begin
      cycles = cycles + 1;
      if (cycles == 4000) begin
         err_total++;
         conclude();
      end
   end
   // ----
   // scenarios
   // ----
   initial begin
      repeat (20) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      @(posedge i_clk_sys);
      for (i = 0; i < 17; i++) bus_rd(i[4:0], 32'h0);
      for (i = 0; i < 8; i++) begin
         r[i] = rnd();
         bus_wr(i[4:0], r[i], 4'hf);
      end
      for (i = 0; i < 8; i++) bus_rd(i[4:0], r[i]);
      core_rd(4'h2, `SIZE_DWORD, r[2]);
      // narrow writes keep the upper part
      v = rnd();
      core_u.issue(3'h0, v, 4'h3, {1'b0, `SIZE_BYTE});
      r[3] = {r[3][31:8], v[7:0]};
      core_u.issue(3'h0, v, 4'h5, {1'b0, `SIZE_WORD});
      r[5] = {r[5][31:16], v[15:0]};
      bus_rd(5'h03, r[3]);
      bus_rd(5'h05, r[5]);
      core_rd(4'h5, `SIZE_BYTE, {24'h0, r[5][7:0]});
      core_rd(4'h5, `SIZE_WORD, {16'h0, r[5][15:0]});
      bus_wr(5'h06, 32'haabbccdd, 4'h3);
      bus_rd(5'h06, {r[6][31:16], 16'hccdd});
      v = rnd();
      bus_wr(`BUS_IDX_MOD, v, 4'hf);
      bus_rd(`BUS_IDX_MOD, {16'h0, v[15:0]});
      core_rd(`SEL_MOD, `SIZE_DWORD, {16'h0, v[15:0]});
      v = rnd();
      core_u.issue(3'h1, v, 4'h0, 3'h0);
      bus_rd(`BUS_IDX_PC, v);
      core_rd(`SEL_PC, `SIZE_DWORD, v);
      // stacks: interrupt one in use after reset
      bus_wr(`BUS_IDX_ISP, 32'h00001000, 4'hf);
      bus_wr(`BUS_IDX_USP, 32'h00002000, 4'hf);
      core_u.issue(3'h2, v, 4'h0, 3'h4);
      core_u.issue(3'h3, v, 4'h0, 3'h2);
      bus_rd(`BUS_IDX_ISP, 32'h00000ffe);
      core_u.issue(3'h6, 32'h1, 4'h0, 3'h0);
      bus_rd(`BUS_IDX_CTRL, 32'h1);
      core_u.issue(3'h2, v, 4'h0, 3'h1);
      bus_rd(`BUS_IDX_USP, 32'h00001fff);
      core_rd(`SEL_SP, `SIZE_DWORD, 32'h00001fff);
      core_rd(`SEL_ISP_DIRECT, `SIZE_DWORD, 32'h00000ffe);
      core_u.issue(3'h7, v, 4'h0, 3'h0);
      bus_rd(`BUS_IDX_CTRL, 32'h0);
      core_rd(`SEL_SP, `SIZE_DWORD, 32'h00000ffe);
      core_rd(`SEL_USP_DIRECT, `SIZE_DWORD, 32'h00001fff);
      core_u.issue(3'h0, 32'h00003000, `SEL_USP_DIRECT, {1'b0, `SIZE_DWORD});
      bus_rd(`BUS_IDX_USP, 32'h00003000);
      // procedure entry then exit on the interrupt stack
      core_u.issue(3'h4, v, 4'h0, 3'h0);
      bus_rd(`BUS_IDX_FP, 32'h00000ffa);
      bus_rd(`BUS_IDX_ISP, 32'h00000ffa);
      core_u.issue(3'h5, 32'h00000055, 4'h0, 3'h0);
      bus_rd(`BUS_IDX_FP, 32'h00000055);
      view_rd(2'h1, 32'h00000055);
      bus_rd(`BUS_IDX_ISP, 32'h00000ffe);
      v = rnd();
      bus_wr(`BUS_IDX_SB, 32'hfffffffc, 4'hf);
      bus_wr(`BUS_IDX_DISPATCH_TABLE_BASE, v, 4'hf);
      bus_rd(`BUS_IDX_SB, 32'hfffffffc);
      view_rd(2'h2, 32'hfffffffc);
      core_rd(`SEL_SB, `SIZE_DWORD, 32'hfffffffc);
      bus_rd(`BUS_IDX_DISPATCH_TABLE_BASE, v);
      view_rd(2'h3, v);
      bus_wr(5'h13, v, 4'hf);
      bus_rd(5'h13, 32'h0);
      conclude();
   end
endmodule
